// ### logic/isp_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "isp_cfg.svh"

// Overview of operation
// RQ1: Works with serial clock up to 1 MHz
// RQ2: Filter out spikes of 50 ns or less
// RQ3: Slave only; clock is input, data bidirectional
// RQ4: Zero pulls data low, one releases line
// RQ5: Change data while clock low, sample rising
// RQ6: Data driver released while bus idle
// RQ7: Start condition opens transfer, expects address
// RQ8: Answer 011101x, x from select pin
// RQ9: Acknowledge own address on ninth clock
// RQ10: Write: pointer byte, then data to successive registers
// RQ11: Read from pointer, advancing after each byte
// RQ12: Receiver acknowledges every byte
// RQ13: Stop ends transfer, idle, release data
// RQ14: Repeated start begins new address phase
// RQ15: Master leaves last read byte unacknowledged
// RQ16: Master holds internal reset while reprogramming; no internal reset here, writes land at any time
// RQ17: Register access allowed during video processing
// RQ18: Byte registers; wide values low byte first
// RQ19: Ignore bus after non-matching address
module isp_slave
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_addr_select_pin,
  // Video core side
  input wire isp_status_t i_status,
  output isp_probe_t o_probe
);

  ////////////////////////////////////////////////////////////////////////
  localparam int FILT_N = `ISP_FILT_CYCLES; // RQ1

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [FILT_N-1:0] scl_hist;
  logic [FILT_N-1:0] sda_hist;
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;
  logic sel_sync0;
  logic sel_sync1;

  // Two-flop synchronisers, then a run-length filter
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync0 <= 1'b0;
      sel_sync1 <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      sel_sync0 <= i_addr_select_pin;
      sel_sync1 <= sel_sync0;
    end
  end

  wire scl_all_hi = &{scl_hist, scl_sync[1]};
  wire scl_all_lo = ~|{scl_hist, scl_sync[1]};
  wire sda_all_hi = &{sda_hist, sda_sync[1]};
  wire sda_all_lo = ~|{sda_hist, sda_sync[1]};

  // A level is accepted only after it held longer than a glitch
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_hist <= '1;
      sda_hist <= '1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_hist <= {scl_hist[FILT_N-2:0], scl_sync[1]};
      sda_hist <= {sda_hist[FILT_N-2:0], sda_sync[1]};
      if (scl_all_hi) scl_f <= 1'b1; // RQ2
      else if (scl_all_lo) scl_f <= 1'b0; // RQ2
      if (sda_all_hi) sda_f <= 1'b1; // RQ2
      else if (sda_all_lo) sda_f <= 1'b0; // RQ2
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_d; // RQ5
  wire scl_fall = ~scl_f & scl_d;
  wire start_det = scl_f & scl_d & sda_d & ~sda_f; // RQ7 RQ14
  wire stop_det = scl_f & scl_d & ~sda_d & sda_f; // RQ13

  ////////////////////////////////////////////////////////////////////////
  isp_state_t state;
  isp_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] pointer;
  logic ptr_loaded;
  logic rd_mode;
  logic drive_low;
  logic [7:0] scratch;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] scr, input isp_status_t st);
    logic [7:0] v;
    v = `ISP_RST_BYTE;
    case (a)
      `ISP_REG_SCRATCH: v = scr;
      `ISP_REG_SYNC_FLAGS: v = st.sync_flags;
      `ISP_REG_LINES_LO: v = st.frame_line_lo; // RQ18
      `ISP_REG_LINES_HI: v = {5'h00, st.frame_line_hi}; // RQ18
      `ISP_REG_CLKS_LO: v = st.line_clk_lo;
      `ISP_REG_CLKS_HI: v = {4'h0, st.line_clk_hi};
      `ISP_REG_SAMP_R: v = st.sample_r;
      `ISP_REG_SAMP_G: v = st.sample_g;
      `ISP_REG_SAMP_B: v = st.sample_b;
      `ISP_REG_DARK_ROWS: v = st.dark_rows;
      `ISP_REG_DARK_COLS: v = st.dark_cols;
      default: v = `ISP_RST_BYTE;
    endcase
    return v;
  endfunction : read_reg

  wire byte_done = scl_fall & (bit_cnt == 4'h8);
  wire [7:0] rx_byte = shreg;
  wire addr_match = (rx_byte[7:2] == `ISP_DEV_ADDR_HI) && (rx_byte[1] == sel_sync1); // RQ8
  wire [7:0] rd_data = read_reg(pointer, scratch, i_status);
  wire [7:0] next_ptr = pointer + 8'h01;

  always_comb begin
    next_state = state;
    case (state)
      ISP_IDLE: next_state = state;
      ISP_ADDR: if (byte_done) next_state = addr_match ? ISP_ADDR_ACK : ISP_IGNORE; // RQ19
      ISP_ADDR_ACK: if (scl_fall) next_state = rd_mode ? ISP_RD_BYTE : ISP_WR_BYTE;
      ISP_WR_BYTE: if (byte_done) next_state = ISP_WR_ACK;
      ISP_WR_ACK: if (scl_fall) next_state = ISP_WR_BYTE;
      ISP_RD_BYTE: if (byte_done) next_state = ISP_RD_ACK;
      ISP_RD_ACK: if (scl_rise) next_state = sda_f ? ISP_IGNORE : ISP_RD_BYTE; // RQ12 RQ15
      ISP_IGNORE: next_state = state;
      default: next_state = ISP_IDLE;
    endcase
    if (start_det) next_state = ISP_ADDR; // RQ7 RQ14
    else if (stop_det) next_state = ISP_IDLE; // RQ13
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) state <= ISP_IDLE;
    else state <= next_state;
  end

  // Bit counter and shift register; bits taken on rising clock
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (start_det || next_state != state) begin
      bit_cnt <= 4'h0;
      if (next_state == ISP_RD_BYTE) shreg <= rd_data; // RQ11
    end else if (scl_rise && (state == ISP_ADDR || state == ISP_WR_BYTE)) begin
      shreg <= {shreg[6:0], sda_f}; // RQ5
      bit_cnt <= bit_cnt + 4'h1;
    end else if (state == ISP_RD_BYTE && scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (state == ISP_RD_BYTE && scl_fall && bit_cnt != 4'h0) begin
      shreg <= {shreg[6:0], 1'b1};
    end
  end

  // Direction, pointer and register writes
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_mode <= 1'b0;
      ptr_loaded <= 1'b0;
      pointer <= `ISP_RST_BYTE;
      scratch <= `ISP_RST_BYTE;
      o_probe <= '0;
    end else begin
      if (state == ISP_ADDR && byte_done) begin
        rd_mode <= rx_byte[0];
        ptr_loaded <= 1'b0;
      end
      if (state == ISP_WR_BYTE && byte_done) begin
        if (!ptr_loaded) begin
          pointer <= rx_byte; // RQ10
          ptr_loaded <= 1'b1;
        end else begin
          pointer <= next_ptr; // RQ10
          // Writes land at any time, no internal reset needed
          case (pointer) // RQ17
            `ISP_REG_SCRATCH: scratch <= rx_byte;
            `ISP_REG_ROW_LO: o_probe.row[7:0] <= rx_byte; // RQ18
            `ISP_REG_ROW_HI: o_probe.row[10:8] <= rx_byte[2:0]; // RQ18
            `ISP_REG_COL_LO: o_probe.column[7:0] <= rx_byte;
            `ISP_REG_COL_HI: o_probe.column[11:8] <= rx_byte[3:0];
            `ISP_REG_THRESH: o_probe.threshold <= rx_byte;
            default: scratch <= scratch;
          endcase
        end
      end
      if (state == ISP_RD_BYTE && byte_done) pointer <= next_ptr; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain data: only ever pull low, change only with clock low
  wire ack_slot = (state == ISP_ADDR_ACK) || (state == ISP_WR_ACK); // RQ9 RQ12
  wire rd_bit_low = (state == ISP_RD_BYTE) && !shreg[7] && bit_cnt != 4'h8;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      drive_low <= 1'b0; // RQ6
    end else if (start_det || stop_det || next_state == ISP_IDLE || next_state == ISP_IGNORE) begin
      drive_low <= 1'b0; // RQ13 RQ6 RQ19
    end else if (!scl_f) begin
      drive_low <= ack_slot | rd_bit_low; // RQ4 RQ5
    end
  end

  assign o_sda = 1'b0; // RQ3 RQ4
  assign o_sda_oe = drive_low; // RQ4

endmodule : isp_slave
`default_nettype wire

// ### logic/isp_cfg.svh
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
// Bus address, upper six bits; low bit comes from the select pin
`define ISP_DEV_ADDR_HI 6'h1D
// Register offsets
`define ISP_REG_RSVD0 8'h00
`define ISP_REG_RSVD1 8'h01
`define ISP_REG_SCRATCH 8'h02
`define ISP_REG_UNUSED3 8'h03
`define ISP_REG_SYNC_FLAGS 8'h04
`define ISP_REG_LINES_LO 8'h05
`define ISP_REG_LINES_HI 8'h06
`define ISP_REG_CLKS_LO 8'h07
`define ISP_REG_CLKS_HI 8'h08
`define ISP_REG_ROW_LO 8'h09
`define ISP_REG_ROW_HI 8'h0A
`define ISP_REG_COL_LO 8'h0B
`define ISP_REG_COL_HI 8'h0C
`define ISP_REG_THRESH 8'h0D
`define ISP_REG_SAMP_R 8'h0E
`define ISP_REG_SAMP_G 8'h0F
`define ISP_REG_SAMP_B 8'h10
`define ISP_REG_DARK_ROWS 8'h11
`define ISP_REG_DARK_COLS 8'h12
// Reset values
`define ISP_RST_BYTE 8'h00
// Timing: system clock period and glitch width, in ns
`define ISP_CLK_PERIOD_NS 25
`define ISP_GLITCH_NS 50
`define ISP_FILT_CYCLES ((`ISP_GLITCH_NS + `ISP_CLK_PERIOD_NS - 1) / `ISP_CLK_PERIOD_NS + 1)
`define ISP_MAX_SCL_KHZ 1000
`endif

// ### logic/isp_pkg.sv
package isp_pkg;
  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_ADDR,
    ISP_ADDR_ACK,
    ISP_WR_BYTE,
    ISP_WR_ACK,
    ISP_RD_BYTE,
    ISP_RD_ACK,
    ISP_IGNORE
  } isp_state_t;

  typedef struct packed {
    logic [2:0] frame_line_hi;
    logic [7:0] frame_line_lo;
    logic [3:0] line_clk_hi;
    logic [7:0] line_clk_lo;
    logic [7:0] sync_flags;
    logic [7:0] sample_r;
    logic [7:0] sample_g;
    logic [7:0] sample_b;
    logic [7:0] dark_rows;
    logic [7:0] dark_cols;
  } isp_status_t;

  typedef struct packed {
    logic [10:0] row;
    logic [11:0] column;
    logic [7:0] threshold;
  } isp_probe_t;
endpackage : isp_pkg

// ### test/isp_slave_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "isp_cfg.svh"
module isp_slave_assertions (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_addr_select_pin
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic ps, pd, adr, mw, mr, nk;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire st = ps & i_scl & pd & !i_sda;
  wire sp = ps & i_scl & !pd & i_sda;
  wire rise = !ps & i_scl;
  wire fall = ps & !i_scl;
  wire hit = sh[7:1] == {`ISP_DEV_ADDR_HI, i_addr_select_pin};
  wire ack_due = fall && cnt == 4'h8 && (adr ? hit : mw);
  // Bit count and address decode since the last start
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {ps, pd, adr, mw, mr, nk, cnt, sh} <= {2'h3, 16'h0000};
    end else begin
      {ps, pd} <= {i_scl, i_sda};
      if (st || sp) begin
        {adr, mw, mr, nk, cnt} <= {st, 7'h00};
      end else if (rise) begin
        sh <= {sh[6:0], i_sda};
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt == 4'h8) begin
          {adr, mw, mr} <= adr ? {1'b0, hit & ~sh[0], hit & sh[0]} : {1'b0, mw, mr};
          nk <= nk | (mr & i_sda);
        end
      end
    end
  end
  property p_zero; o_sda_oe |-> !o_sda; endproperty
  a_zero: assert property (p_zero) else $error("a_zero");
  property p_low; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_low: assert property (p_low) else $error("a_low");
  property p_quiet; adr && cnt < 4'h8 |-> !o_sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("a_quiet");
  property p_ack; ack_due |-> ##[1:12] o_sda_oe; endproperty
  a_ack: assert property (p_ack) else $error("a_ack");
  property p_miss; fall && cnt == 4'h8 && adr && !hit |=> !o_sda_oe [*8]; endproperty
  a_miss: assert property (p_miss) else $error("a_miss");
  property p_nack; nk |-> !o_sda_oe; endproperty
  a_nack: assert property (p_nack) else $error("a_nack");
  property p_stop; sp |=> !o_sda_oe [*8]; endproperty
  a_stop: assert property (p_stop) else $error("a_stop");
  property p_idle; cnt == 4'h0 && !adr |-> !o_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("a_idle");
  c_ack: cover property (ack_due);
  c_nack: cover property (nk);
  c_stop: cover property (sp);
endmodule : isp_slave_assertions
bind isp_slave isp_slave_assertions u_chk (.i_clock, .i_arst_n, .i_scl, .i_sda, .o_sda, .o_sda_oe,
  .i_addr_select_pin);
`default_nettype wire

// ### test/isp_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module isp_bus_master (
  // Bus lines
  output var logic o_scl,
  output var logic o_sda_low,
  input wire logic i_sda
);
  // Quarter of a 1 MHz bus period
  localparam int Q = 250;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic start_cond();
    o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b0;
    #Q;
  endtask : start_cond
  task automatic stop_cond();
    o_sda_low = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b0;
    #Q;
  endtask : stop_cond
  task automatic xfer(input logic b, output logic r);
    o_sda_low = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask : xfer
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(v[i], r);
    end
    xfer(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      v[i] = r;
    end
    xfer(last, r);
  endtask : get_byte
endmodule : isp_bus_master
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import isp_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic scl, m_low, s_out, s_oe, ak;
  logic [7:0] rd;
  isp_status_t st;
  isp_probe_t pr;
  int err_count = 0;
  int checks_done = 0;
  wire sda = (s_oe ? s_out : 1'b1) & !m_low;
  always #12.5 clk = ~clk;
  isp_bus_master mst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
  isp_slave dut (.i_clock(clk), .i_arst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(s_out),
    .o_sda_oe(s_oe), .i_addr_select_pin(sel), .i_status(st), .o_probe(pr));
  ////////////////////////////////////////
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      8'h02: return 8'hAB;
      8'h04: return st.sync_flags;
      8'h05: return st.frame_line_lo;
      8'h06: return {5'h00, st.frame_line_hi};
      8'h07: return st.line_clk_lo;
      8'h08: return {4'h0, st.line_clk_hi};
      8'h0E: return st.sample_r;
      8'h0F: return st.sample_g;
      8'h10: return st.sample_b;
      8'h11: return st.dark_rows;
      8'h12: return st.dark_cols;
      default: return 8'h00;
    endcase
  endfunction : exp_reg
  task automatic addr_phase(input logic [7:0] dev, input logic ea);
    mst.start_cond();
    mst.send_byte(dev, ak);
    check("addr ack", ak, ea);
  endtask : addr_phase
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] q[$]);
    addr_phase({6'h1D, sel, 1'b0}, 1'b1);
    mst.send_byte(ptr, ak);
    foreach (q[i]) begin
      mst.send_byte(q[i], ak);
      check("data ack", ak, 1'b1);
    end
    mst.stop_cond();
  endtask : reg_write
  task automatic reg_read(input int ptr, input int a, input int n);
    if (ptr >= 0) begin
      addr_phase({6'h1D, sel, 1'b0}, 1'b1);
      mst.send_byte(8'(ptr), ak);
    end
    addr_phase({6'h1D, sel, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.get_byte(i == n - 1, rd);
      check("read", rd, exp_reg(8'(a + i)));
    end
    mst.stop_cond();
  endtask : reg_read
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    st = '{3'h6, 8'h15, 4'hC, 8'h27, 8'h41, 8'h5E, 8'h6F, 8'h70, 8'h81, 8'h92};
    repeat (6) @(negedge clk);
    check("probe rst", pr, 32'h0);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    reg_write(8'h01, '{8'h11, 8'hAB, 8'h22, 8'h33});
    reg_write(8'h09, '{8'h34, 8'hFD, 8'h78, 8'hF9, 8'h5A});
    check("probe", pr, {1'b0, 11'h534, 12'h978, 8'h5A});
    reg_read(0, 0, 5);
    reg_read(-1, 5, 4);
    reg_read(14, 14, 5);
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      for (int d = 0; d < 2; d++) begin
        addr_phase({6'h1D, d[0], 1'b0}, d == s);
        mst.stop_cond();
      end
    end
    reg_read(2, 2, 1);
    tally_and_finish();
  end
  // Hang guard
  initial begin
    #2ms;
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
